// ---- pkg/lcm_pkg.sv ----
/*
 * lcm_pkg: constants and carrier types for the link configuration and
 * modem control block. Assumes a 250 MHz core clock.
 */
package lcm_pkg;
    // ------------------------------------------------------------
    // clock and rates
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250000000;
    localparam int TP_RATE_BPS = 20000;
    localparam int ASYNC_MIN_BPS = 150;
    localparam int ASYNC_MAX_BPS = 1200;
    localparam int ASYNC_DBL_MAX_BPS = 2400;
    localparam int SYNC_MAX_BPS = 19200;
    localparam int TP_DIV = CLK_HZ / TP_RATE_BPS;
    // ------------------------------------------------------------
    // switch fields and reset values
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int FUNC_W = 12;
    localparam int OPT_LSB = 5;
    localparam int OPT_W = 7;
    localparam logic [4:0] ADDR_FACTORY = 5'h11;
    localparam logic [4:0] ADDR_MAX = 5'h1e;
    localparam logic [4:0] ADDR_UNLISTEN = 5'h1f;
    localparam logic [6:0] OPT_RESET = 7'h00;
    // ------------------------------------------------------------
    // medium selector codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_ASYNC_0 = 4'h0;
    localparam logic [3:0] SEL_ASYNC_3 = 4'h3;
    localparam logic [3:0] SEL_SYNC_0 = 4'h4;
    localparam logic [3:0] SEL_SYNC_2 = 4'h6;
    localparam logic [3:0] SEL_TP = 4'h7;
    localparam logic [3:0] SEL_TEST_0 = 4'h8;
    localparam logic [3:0] SEL_TEST_2 = 4'ha;
    localparam logic [3:0] SEL_RESET = 4'hf;

    typedef enum logic [1:0] {
        LCM_MODE_LOCAL,
        LCM_MODE_REMOTE,
        LCM_MODE_REMOTE_MP
    } lcm_mode_t;

    typedef enum logic [2:0] {
        LCM_MED_NONE,
        LCM_MED_ASYNC,
        LCM_MED_SYNC,
        LCM_MED_TP,
        LCM_MED_TEST
    } lcm_medium_t;

    typedef struct packed {
        logic [4:0] bus_addr;
        logic [4:0] mp_addr;
        logic addr_valid;
        logic opts_ok;
    } lcm_addr_t;

    typedef struct packed {
        logic rts;
        logic dtr;
        logic call_up;
        logic cts_led;
        logic dsr_led;
    } lcm_modem_t;
endpackage

// ---- verilog/lcm_fifo.sv ----
/*
 * lcm_fifo: small synchronous valid/ready FIFO.
 * Assumes a single clock and active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module lcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign push = in_valid_in && !full;
    assign pop = !empty && out_ready_in;
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/lcm_link_config_modem.sv ----
/*
 * lcm_link_config_modem: switch decode, bit-rate selection, serial data
 * path through a FIFO and modem handshake control.
 * Assumes switches, selector, modem lines and modem clocks are async pins.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - low five switches give bus or station address
// - remote mode ignores address unless multi-point
// - factory address octal 21
// - multi-point station address independent, 0..36
// - options six to twelve off in remote
// - async positions generate 150 to 1200 bps
// - doubling link doubles async rate to 2400
// - sync positions time bits from modem clock
// - twisted pair fixed at 20k bps
// - three test positions on selector
// - unused selector positions have no link function
// - transmit data out, receive data in
// - request-to-send on except idle cases
// - clear-to-send and data-set-ready mean call up
// - indicators follow clear-to-send and data-set-ready
// - terminal-ready on, drops on disconnect while dialled, or on override
// - sync transmit on tx clock, receive on rx clock
module lcm_link_config_modem #(
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [11:0] func_sw_in,
    input wire logic [3:0] medium_sw_in,
    input wire logic [1:0] mode_in,
    input wire logic dbl_link_in,
    input wire logic dialled_in,
    input wire logic dialling_done_in,
    input wire logic disconnect_in,
    input wire logic mp_addressed_in,
    input wire logic dtr_override_in,
    input wire logic cts_in,
    input wire logic dsr_in,
    input wire logic rx_data_in,
    input wire logic tx_clk_in,
    input wire logic rx_clk_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic [DATA_W-1:0] tx_byte_in,
    output logic tx_data_out,
    output logic rts_out,
    output logic dtr_out,
    output logic call_up_out,
    output logic cts_led_out,
    output logic dsr_led_out,
    output logic [4:0] bus_addr_out,
    output logic [4:0] mp_addr_out,
    output logic addr_valid_out,
    output logic opts_ok_out,
    output logic [2:0] medium_out,
    output logic test_mode_out,
    output logic rx_bit_out,
    output logic rx_bit_valid_out
);
    if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
        $error("data width out of range");
    end

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    localparam int NS = 12 + 4 + 2 + 1 + 7;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {func_sw_in, medium_sw_in, mode_in, dbl_link_in,
                     cts_in, dsr_in, rx_data_in, tx_clk_in, rx_clk_in,
                     dtr_override_in, disconnect_in};
            s2_q <= s1_q;
        end
    end
    logic [11:0] fsw;
    logic [3:0] msw;
    logic [1:0] mode_s;
    logic dbl_s, cts_s, dsr_s, rxd_s, txc_s, rxc_s, ovr_s, disc_s;
    assign {fsw, msw, mode_s, dbl_s, cts_s, dsr_s, rxd_s, txc_s, rxc_s,
            ovr_s, disc_s} = s2_q;

    // ------------------------------------------------------------
    // static configuration
    // ------------------------------------------------------------
    logic [11:0] fsw_q;
    logic [3:0] msw_q;
    logic [1:0] mode_q;
    logic dbl_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fsw_q <= {lcm_pkg::OPT_RESET, lcm_pkg::ADDR_FACTORY};
            msw_q <= lcm_pkg::SEL_RESET;
            mode_q <= 2'h0;
            dbl_q <= 1'b0;
        end else begin
            fsw_q <= fsw;
            msw_q <= msw;
            mode_q <= mode_s;
            dbl_q <= dbl_s;
        end
    end

    function automatic lcm_pkg::lcm_medium_t decode_medium(
            input logic [3:0] sel);
        if (sel <= lcm_pkg::SEL_ASYNC_3) begin
            decode_medium = lcm_pkg::LCM_MED_ASYNC;
        end else if (sel <= lcm_pkg::SEL_SYNC_2) begin
            decode_medium = lcm_pkg::LCM_MED_SYNC;
        end else if (sel == lcm_pkg::SEL_TP) begin
            decode_medium = lcm_pkg::LCM_MED_TP;
        end else if (sel >= lcm_pkg::SEL_TEST_0
                     && sel <= lcm_pkg::SEL_TEST_2) begin
            decode_medium = lcm_pkg::LCM_MED_TEST;
        end else begin
            decode_medium = lcm_pkg::LCM_MED_NONE;
        end
    endfunction

    lcm_pkg::lcm_medium_t med;
    assign med = decode_medium(msw_q);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    lcm_pkg::lcm_addr_t addr_d;
    lcm_pkg::lcm_addr_t addr_q;
    logic [4:0] sw_addr;
    assign sw_addr = fsw_q[lcm_pkg::ADDR_W-1:0];
    always_comb begin
        addr_d = '0;
        addr_d.opts_ok = 1'b1;
        case (mode_q)
            2'h0: begin
                addr_d.bus_addr = sw_addr;
                addr_d.addr_valid = (sw_addr <= lcm_pkg::ADDR_MAX);
            end
            2'h1: begin
                // address switches are don't care here
                addr_d.opts_ok = (fsw_q[11:lcm_pkg::OPT_LSB] == '0);
            end
            2'h2: begin
                addr_d.mp_addr = sw_addr;
                addr_d.addr_valid = (sw_addr <= lcm_pkg::ADDR_MAX);
                addr_d.opts_ok = (fsw_q[11:lcm_pkg::OPT_LSB] == '0);
            end
            default: begin
                addr_d.opts_ok = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    // ------------------------------------------------------------
    // bit-rate enable
    // ------------------------------------------------------------
    localparam int RW = 24;
    function automatic logic [RW-1:0] async_div(input logic [1:0] idx,
                                               input logic dbl);
        logic [RW-1:0] d;
        d = '0;
        case (idx)
            2'h0: d = RW'(lcm_pkg::CLK_HZ / lcm_pkg::ASYNC_MIN_BPS);
            2'h1: d = RW'(lcm_pkg::CLK_HZ / 300);
            2'h2: d = RW'(lcm_pkg::CLK_HZ / 600);
            default: d = RW'(lcm_pkg::CLK_HZ / lcm_pkg::ASYNC_MAX_BPS);
        endcase
        async_div = dbl ? (d >> 1) : d;
    endfunction

    logic [RW-1:0] div_lim;
    logic [RW-1:0] div_q;
    logic int_tick;
    always_comb begin
        if (med == lcm_pkg::LCM_MED_TP) begin
            div_lim = RW'(lcm_pkg::TP_DIV);
        end else begin
            div_lim = async_div(msw_q[1:0], dbl_q);
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_q <= '0;
        end else if (div_q >= div_lim - 1'b1) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign int_tick = (div_q >= div_lim - 1'b1);

    // edge detection on the synchronised modem clocks
    logic txc_q, rxc_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            txc_q <= 1'b0;
            rxc_q <= 1'b0;
        end else begin
            txc_q <= txc_s;
            rxc_q <= rxc_s;
        end
    end
    logic txc_fall, rxc_rise, link_on, tx_tick, rx_tick;
    assign txc_fall = txc_q && !txc_s;
    assign rxc_rise = !rxc_q && rxc_s;
    assign link_on = (med == lcm_pkg::LCM_MED_ASYNC)
                     || (med == lcm_pkg::LCM_MED_SYNC)
                     || (med == lcm_pkg::LCM_MED_TP);
    // sync: launch on tx clock fall, sample on rx clock rise
    assign tx_tick = (med == lcm_pkg::LCM_MED_SYNC) ? txc_fall
                     : (link_on && int_tick);
    assign rx_tick = (med == lcm_pkg::LCM_MED_SYNC) ? rxc_rise
                     : (link_on && int_tick);

    // ------------------------------------------------------------
    // transmit path: fifo then shifter
    // ------------------------------------------------------------
    logic f_valid, f_ready;
    logic [DATA_W-1:0] f_data;
    logic f_in_ready;
    lcm_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(f_in_ready),
        .in_data_in(tx_byte_in),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready),
        .out_data_out(f_data)
    );
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= f_in_ready;
        end
    end

    localparam int CW = $clog2(DATA_W + 1);
    logic [DATA_W-1:0] sh_q;
    logic [CW-1:0] cnt_q;
    logic busy;
    assign busy = (cnt_q != '0);
    assign f_ready = !busy && tx_tick && rts_out;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sh_q <= '0;
            cnt_q <= '0;
        end else if (f_ready && f_valid) begin
            sh_q <= f_data;
            cnt_q <= CW'(DATA_W);
        end else if (busy && tx_tick) begin
            sh_q <= sh_q >> 1;
            cnt_q <= cnt_q - 1'b1;
        end
    end
    // idle line is mark
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_data_out <= 1'b1;
        end else if (busy && tx_tick) begin
            tx_data_out <= sh_q[0];
        end else if (!busy && tx_tick) begin
            tx_data_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_bit_out <= 1'b1;
            rx_bit_valid_out <= 1'b0;
        end else begin
            rx_bit_valid_out <= rx_tick;
            if (rx_tick) begin
                rx_bit_out <= rxd_s;
            end
        end
    end

    // ------------------------------------------------------------
    // modem handshake
    // ------------------------------------------------------------
    logic drop_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            drop_q <= 1'b0;
        end else if (disc_s && dialled_in) begin
            drop_q <= 1'b1;
        end else if (!dsr_s) begin
            drop_q <= 1'b0;
        end
    end
    logic disc_seen_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            disc_seen_q <= 1'b0;
        end else if (disc_s) begin
            disc_seen_q <= 1'b1;
        end else if (dialling_done_in) begin
            disc_seen_q <= 1'b0;
        end
    end
    lcm_pkg::lcm_modem_t mdm_d;
    always_comb begin
        mdm_d.rts = !(dialled_in && !dialling_done_in) && !disc_seen_q
                    && !(mode_q == 2'h2 && !mp_addressed_in);
        mdm_d.dtr = !drop_q && !ovr_s;
        mdm_d.call_up = cts_s && dsr_s;
        mdm_d.cts_led = cts_s;
        mdm_d.dsr_led = dsr_s;
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {rts_out, dtr_out, call_up_out, cts_led_out, dsr_led_out}
                <= 5'h0;
        end else begin
            {rts_out, dtr_out, call_up_out, cts_led_out, dsr_led_out}
                <= mdm_d;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_addr_out <= '0;
            mp_addr_out <= '0;
            addr_valid_out <= 1'b0;
            opts_ok_out <= 1'b0;
            medium_out <= '0;
            test_mode_out <= 1'b0;
        end else begin
            bus_addr_out <= addr_q.bus_addr;
            mp_addr_out <= addr_q.mp_addr;
            addr_valid_out <= addr_q.addr_valid;
            opts_ok_out <= addr_q.opts_ok;
            medium_out <= 3'(med);
            test_mode_out <= (med == lcm_pkg::LCM_MED_TEST);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_led_follow;
        @(posedge clk_in) disable iff (!rst_b_in)
        $changed(cts_s) |-> ##1 (cts_led_out == $past(cts_s)); 
    endproperty
    a_led_follow: assert property (p_led_follow)
        else $error("cts indicator does not follow modem");
    property p_call_up;
        @(posedge clk_in) disable iff (!rst_b_in)
        ##1 (call_up_out == ($past(cts_s) && $past(dsr_s)));
    endproperty
    a_call_up: assert property (p_call_up)
        else $error("call status wrong");
    property p_dtr_override;
        @(posedge clk_in) disable iff (!rst_b_in)
        ovr_s [*2] |-> !dtr_out;
    endproperty
    a_dtr_override: assert property (p_dtr_override)
        else $error("terminal ready not dropped under override");
    property p_mp_rts;
        @(posedge clk_in) disable iff (!rst_b_in)
        (mode_q == 2'h2 && !mp_addressed_in) |=> !rts_out;
    endproperty
    a_mp_rts: assert property (p_mp_rts)
        else $error("request to send at unaddressed station");
    property p_unused_quiet;
        @(posedge clk_in) disable iff (!rst_b_in)
        (med == lcm_pkg::LCM_MED_NONE || med == lcm_pkg::LCM_MED_TEST)
            |-> !rx_tick;
    endproperty
    a_unused_quiet: assert property (p_unused_quiet)
        else $error("link active in unused position");
    // first tick after a switch may come early while the count wraps
    property p_tp_rate;
        @(posedge clk_in) disable iff (!rst_b_in)
        (med == lcm_pkg::LCM_MED_TP && $past(med) == lcm_pkg::LCM_MED_TP
            && int_tick) |-> (div_q == RW'(lcm_pkg::TP_DIV - 1));
    endproperty
    a_tp_rate: assert property (p_tp_rate)
        else $error("twisted pair rate wrong");
    property p_remote_opts;
        @(posedge clk_in) disable iff (!rst_b_in)
        (mode_q == 2'h1 && fsw_q[11:5] != '0) |=> !addr_q.opts_ok;
    endproperty
    a_remote_opts: assert property (p_remote_opts)
        else $error("remote option switches not flagged");
    property p_mp_addr;
        @(posedge clk_in) disable iff (!rst_b_in)
        (mode_q == 2'h2) |=> (addr_q.mp_addr == $past(sw_addr));
    endproperty
    a_mp_addr: assert property (p_mp_addr)
        else $error("station address not taken");
    property p_sync_tick;
        @(posedge clk_in) disable iff (!rst_b_in)
        ($past(med) == lcm_pkg::LCM_MED_SYNC && $changed(tx_data_out))
            |-> $past(txc_fall);
    endproperty
    a_sync_tick: assert property (p_sync_tick)
        else $error("sync transmit off modem clock");
endmodule
`default_nettype wire

// ---- bench/lcm_modem_model.sv ----
/*
 * lcm_modem_model: far-side synchronous modem, handshake lines and clocks.
 * Assumes the bench sets the control levels after core clock edges.
 */
`timescale 1ns/100ps
`default_nettype none
module lcm_modem_model (
    input wire logic run_in,
    input wire logic cts_set_in,
    input wire logic dsr_set_in,
    input wire logic rx_pat_in,
    output logic tx_clk_out,
    output logic rx_clk_out,
    output logic cts_out,
    output logic dsr_out,
    output var logic rx_data_out
);
    // clocks stand low between frames, 80 ns period while running
    initial begin
        tx_clk_out = 1'b0;
        forever begin
            #40;
            tx_clk_out = run_in ? ~tx_clk_out : 1'b0;
        end
    end
    // skewed so receive edges never line up with transmit edges
    assign #13 rx_clk_out = tx_clk_out;
    initial rx_data_out = 1'b1;
    always @(negedge rx_clk_out) begin
        rx_data_out <= rx_pat_in;
    end
    assign cts_out = cts_set_in;
    assign dsr_out = dsr_set_in;
endmodule
`default_nettype wire

// ---- bench/test_lcm_link_config_modem.sv ----
/*
 * test_lcm_link_config_modem: directed bench for switch decode, medium
 * select, modem lines, serial path and FIFO. Assumes lcm_pkg compiled.
 */
`timescale 1ns/100ps
`default_nettype none
module test_lcm_link_config_modem;
    logic clk_in, rst_b_in, dbl_link_in, dialled_in, dialling_done_in;
    logic disconnect_in, mp_addressed_in, dtr_override_in, cts_in, dsr_in;
    logic rx_data_in, tx_clk_in, rx_clk_in, tx_valid_in, tx_ready_out;
    logic tx_data_out, rts_out, dtr_out, call_up_out, cts_led_out;
    logic dsr_led_out, addr_valid_out, opts_ok_out, test_mode_out;
    logic rx_bit_out, rx_bit_valid_out, run, cts_set, dsr_set, rx_pat;
    logic [11:0] func_sw_in;
    logic [3:0] medium_sw_in;
    logic [1:0] mode_in;
    logic [7:0] tx_byte_in, got;
    logic [4:0] bus_addr_out, mp_addr_out;
    logic [2:0] medium_out;
    int bad_count, n_tests, cycles, n;

    lcm_link_config_modem i_lcm_link_config_modem (
        .clk_in, .rst_b_in, .func_sw_in, .medium_sw_in, .mode_in,
        .dbl_link_in, .dialled_in, .dialling_done_in, .disconnect_in,
        .mp_addressed_in, .dtr_override_in, .cts_in, .dsr_in, .rx_data_in,
        .tx_clk_in, .rx_clk_in, .tx_valid_in, .tx_ready_out, .tx_byte_in,
        .tx_data_out, .rts_out, .dtr_out, .call_up_out, .cts_led_out,
        .dsr_led_out, .bus_addr_out, .mp_addr_out, .addr_valid_out,
        .opts_ok_out, .medium_out, .test_mode_out, .rx_bit_out,
        .rx_bit_valid_out);
    lcm_modem_model i_lcm_modem_model (.run_in(run), .cts_set_in(cts_set),
        .dsr_set_in(dsr_set), .rx_pat_in(rx_pat), .tx_clk_out(tx_clk_in),
        .rx_clk_out(rx_clk_in), .cts_out(cts_in), .dsr_out(dsr_in),
        .rx_data_out(rx_data_in));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rx_try(input logic b);
        int k;
        rx_pat = b;
        cyc(60);
        k = 0;
        repeat (200) begin
            cyc(1);
            if (rx_bit_valid_out === 1'b1) begin
                k++;
                chk("rx_bit", rx_bit_out, b);
            end
        end
        chk("rx_seen", k > 0, 1'b1);
    endtask
    function automatic logic [2:0] med_exp(input int s);
        if (s < 4) return 3'h1;
        if (s < 7) return 3'h2;
        if (s == 7) return 3'h3;
        if (s < 11) return 3'h4;
        return 3'h0;
    endfunction

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            end_sim();
        end
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_b_in, dbl_link_in, dialled_in, disconnect_in} = 4'h0;
        {mp_addressed_in, dtr_override_in, tx_valid_in, run} = 4'h0;
        {cts_set, dsr_set, rx_pat, dialling_done_in} = 4'hf;
        func_sw_in = 12'h011;
        medium_sw_in = 4'h7;
        mode_in = lcm_pkg::LCM_MODE_LOCAL;
        tx_byte_in = 8'h00;
        bad_count = 0;
        n_tests = 0;
        cycles = 0;
        cyc(3);
        rst_b_in = 1'b1;
        cyc(8);
        chk("bus_addr", bus_addr_out, 8'h11);
        chk("addr_valid_on", addr_valid_out, 1'b1);
        $display("test address done");
        mode_in = lcm_pkg::LCM_MODE_REMOTE;
        cyc(8);
        chk("addr_valid", addr_valid_out, 1'b0);
        chk("opts_ok", opts_ok_out, 1'b1);
        mode_in = lcm_pkg::LCM_MODE_REMOTE_MP;
        func_sw_in = 12'h01e;
        cyc(8);
        chk("mp_addr", mp_addr_out, 8'h1e);
        chk("rts_unaddressed", rts_out, 1'b0);
        mp_addressed_in = 1'b1;
        func_sw_in = 12'h03e;
        cyc(8);
        chk("rts_addressed", rts_out, 1'b1);
        chk("opts_bad", opts_ok_out, 1'b0);
        $display("test remote done");
        for (int s = 0; s < 16; s++) begin
            medium_sw_in = 4'(s);
            cyc(8);
            chk("medium", medium_out, med_exp(s));
            chk("test_mode", test_mode_out, s > 7 && s < 11);
        end
        $display("test medium done");
        for (int c = 0; c < 4; c++) begin
            {cts_set, dsr_set} = 2'(c);
            cyc(8);
            chk("cts_led", cts_led_out, cts_set);
            chk("dsr_led", dsr_led_out, dsr_set);
            chk("call_up", call_up_out, cts_set & dsr_set);
        end
        chk("dtr_on", dtr_out, 1'b1);
        dtr_override_in = 1'b1;
        cyc(8);
        chk("dtr_override", dtr_out, 1'b0);
        dtr_override_in = 1'b0;
        dialled_in = 1'b1;
        disconnect_in = 1'b1;
        cyc(8);
        chk("rts_disc", rts_out, 1'b0);
        disconnect_in = 1'b0;
        cyc(8);
        chk("dtr_disc", dtr_out, 1'b0);
        dsr_set = 1'b0;
        cyc(8);
        chk("dtr_back", dtr_out, 1'b1);
        $display("test modem lines done");
        rst_b_in = 1'b0;
        {dialled_in, dsr_set, run} = 3'h7;
        mode_in = lcm_pkg::LCM_MODE_LOCAL;
        medium_sw_in = 4'h4;
        cyc(3);
        rst_b_in = 1'b1;
        cyc(10);
        tx_byte_in = 8'h5a;
        tx_valid_in = 1'b1;
        cyc(1);
        tx_valid_in = 1'b0;
        for (int i = 0; i < 300 && tx_data_out !== 1'b0; i++) cyc(1);
        cyc(10);
        for (int i = 0; i < 8; i++) begin
            got[i] = tx_data_out;
            cyc(20);
        end
        chk("tx_byte", got, 8'h5a);
        rx_try(1'b0);
        rx_try(1'b1);
        $display("test serial done");
        medium_sw_in = 4'h7;
        cyc(8);
        for (int i = 0; i < 13000 && rx_bit_valid_out !== 1'b1; i++) cyc(1);
        for (n = 1; n < 13000; n++) begin
            cyc(1);
            if (rx_bit_valid_out === 1'b1) break;
        end
        chk("tp_period", 16'(n), 16'(lcm_pkg::TP_DIV));
        $display("test twisted pair done");
        medium_sw_in = 4'h8;
        cyc(8);
        n = 0;
        for (int i = 0; i < 12 && tx_ready_out === 1'b1; i++) begin
            tx_valid_in = 1'b1;
            cyc(1);
            tx_valid_in = 1'b0;
            n++;
            cyc(2);
        end
        chk("fifo_depth", 8'(n), 8'h08);
        medium_sw_in = 4'h5;
        for (int i = 0; i < 4000 && tx_ready_out !== 1'b1; i++) cyc(1);
        chk("fifo_drain", tx_ready_out, 1'b1);
        $display("test fifo done");
        end_sim();
    end
endmodule
`default_nettype wire
